/* File: logic/ldb_bank.sv */
/*
 * Lead detect and input bias register bank with APB slave, lead-off
 * persistence filters, sticky status and a level interrupt.
 * Assumes comparator and monitor inputs synchronous to ref_clk.
 */
// Implementation choice: register access over APB.
// Functional notes
// - Lead-on detection works only while both measurement channels are off.
// - Lead-off detection works only with a channel on; four status bits.
// - External select 0 senses internal nodes, 1 uses auxiliary pins.
// - Drive monitor enabled flags excessive negative drive swing and interrupts.
// - Polarity 0 positive sources, negative sinks; 1 reverses both.
// - Magnitude 0 disables sources, 1-4 rise, 5-7 all mean 100 nA.
// - Threshold code selects window 215 mV plus 30 mV per step.
// - Lead-off status sets after comparator persists about 128 ms.
// - Fast report skips the persistence delay.
// - Bias code 0,1,2 selects 50,100,200 Mohm; 3 is reserved.
// - Bias enable bit 1 biases positive input, bit 0 negative input.
// - Self-test resistor error is read-only.
// - Status bits reach the interrupt only when enabled.
// - Self-test resistor error reads as eight-bit two's complement, sign extended to 32 bits.
`timescale 1ns/1ps
module ldb_bank import ldb_pkg::*; #(
    parameter int PERSIST_LEN = PERSIST_CYCLES
) (
    input wire logic ref_clk, // System clock
    input wire logic nrst, // Async reset, low active
    input wire logic clk_en, // Freezes all state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [3:0] window_cmp, // {ph, pl, nh, nl} outside window
    input wire logic drive_excess, // Negative drive node swing too large
    input wire logic lead_on_sense, // ULTRA_LOW_POWER lead-on comparator
    input wire logic [7:0] selftest_resistor_error, // Factory trim value
    output logic lead_on_active, // ULTRA_LOW_POWER lead-on detector running
    output logic lead_off_active, // DC lead-off detector running
    output logic external_leadoff_select, // Sense via auxiliary pins
    output logic drive_monitor_active, // Drive monitor running
    output logic pos_source_current, // Positive input sources current
    output logic neg_source_current, // Negative input sources current
    output logic [2:0] leadoff_current_magnitude, // Effective code 0..5
    output logic [9:0] leadoff_window_mv, // Half window in mV
    output logic [1:0] bias_resistance_select, // 0:50 1:100 2:200 Mohm
    output logic pos_input_bias_enable, // Positive input bias switch
    output logic neg_input_bias_enable, // Negative input bias switch
    output logic irq // Level interrupt
);

    if (PERSIST_LEN < 1) begin : g_bad_len
        $error("PERSIST_LEN must be at least one cycle");
    end

    localparam int CNT_W = $clog2(PERSIST_LEN + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERSIST_LEN - 1);

    logic [7:0] dc_cfg_reg;
    logic [7:0] dc_cfg_next;
    logic [3:0] thresh_reg;
    logic [3:0] thresh_next;
    logic [2:0] chan_reg;
    logic [2:0] chan_next;
    logic [3:0] bias_reg;
    logic [3:0] bias_next;
    logic [7:0] int_en_reg;
    logic [7:0] int_en_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [31:0] prdata_next;
    logic pready_next;
    logic pslverr_next;

    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[ADDR_W-1:2];
    endfunction

    // APB decode; answer comes one cycle into the access phase
    wire access_w = psel && penable && !pready;
    wire [7:0] idx_w = reg_index(paddr);
    wire aligned_w = (paddr[1:0] == 2'h0);
    wire hit_dc = (idx_w == IDX_DC_CFG);
    wire hit_thr = (idx_w == IDX_THRESH);
    wire hit_ch = (idx_w == IDX_CHAN_CTRL);
    wire hit_bias = (idx_w == IDX_BIAS_CFG);
    wire hit_ien = (idx_w == IDX_INT_EN);
    wire hit_clr = (idx_w == IDX_INT_CLR);
    wire hit_st = (idx_w == IDX_STATUS);
    wire hit_self = (idx_w == IDX_SELFTEST);
    wire mapped_w = aligned_w && (hit_dc || hit_thr || hit_ch || hit_bias || hit_ien
                                  || hit_clr || hit_st || hit_self);
    // Read-only registers refuse writes; write-only clear reads zero
    wire ro_write_w = pwrite && (hit_st || hit_self);
    wire err_w = !mapped_w || ro_write_w;
    // Writes land at the pready edge, while the master still holds the address
    wire wr_w = psel && penable && pready && pwrite && !err_w;
    wire do_wr_w = wr_w && clk_en;

    wire [7:0] rd_mux_w =
        hit_dc ? dc_cfg_reg :
        hit_thr ? {4'h0, thresh_reg} :
        hit_ch ? {5'h00, chan_reg} :
        hit_bias ? {4'h0, bias_reg} :
        hit_ien ? int_en_reg :
        hit_st ? status_reg :
        hit_self ? selftest_resistor_error :
        8'h00;

    assign pready_next = access_w;
    assign pslverr_next = access_w && err_w;
    // Sign extended so software sees the signed error directly
    assign prdata_next = (access_w && !pwrite && !err_w) ?
        (hit_self ? {{24{selftest_resistor_error[7]}}, selftest_resistor_error}
                  : {24'h000000, rd_mux_w}) : 32'h00000000;

    assign dc_cfg_next = (do_wr_w && hit_dc) ? pwdata[7:0] : dc_cfg_reg;
    assign thresh_next = (do_wr_w && hit_thr) ? pwdata[THR_W-1:0] : thresh_reg;
    assign chan_next = (do_wr_w && hit_ch) ? pwdata[2:0] : chan_reg;
    assign bias_next = (do_wr_w && hit_bias) ? pwdata[3:0] : bias_reg;
    assign int_en_next = (do_wr_w && hit_ien) ? (pwdata[7:0] & ST_MASK) : int_en_reg;

    // Detector qualification by channel state
    wire chan_on_w = chan_reg[CH_I_BIT] || chan_reg[CH_Q_BIT];
    wire lon_run_w = dc_cfg_reg[DC_LON_BIT] && !chan_on_w;
    wire loff_run_w = dc_cfg_reg[DC_LOFF_BIT] && chan_on_w;
    wire drv_run_w = dc_cfg_reg[DC_DRV_BIT];
    wire fast_w = chan_reg[CH_FAST_BIT];

    // Persistence filter per window comparator
    logic [3:0] persist_hit;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_filt
            logic [CNT_W-1:0] cnt_reg;
            logic [CNT_W-1:0] cnt_next;
            wire run_w = loff_run_w && window_cmp[g];
            wire done_w = (cnt_reg == CNT_LAST);
            // Back inside the window or detector stopped: start over
            assign cnt_next = !run_w ? '0 : (done_w ? cnt_reg : cnt_reg + 1'b1);
            assign persist_hit[g] = run_w && (fast_w || done_w);
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_reg <= '0;
                end else if (clk_en) begin
                    cnt_reg <= cnt_next;
                end
            end
        end
    endgenerate

    wire [7:0] events_w;
    assign events_w[ST_LON_BIT] = lon_run_w && lead_on_sense;
    assign events_w[6:5] = 2'h0;
    assign events_w[ST_DRV_BIT] = drv_run_w && drive_excess;
    assign events_w[ST_PH_BIT:ST_NL_BIT] = persist_hit;

    // Write one to clear; a new event in the same cycle wins
    wire [7:0] clr_w = (do_wr_w && hit_clr) ? pwdata[7:0] : 8'h00;
    assign status_next = ((status_reg & ~clr_w) | events_w) & ST_MASK;
    wire irq_next = |(status_next & int_en_next);

    // Effective analog controls
    wire [2:0] mag_w = dc_cfg_reg[DC_MAG_LSB +: MAG_W];
    wire [2:0] mag_eff_w = (mag_w > MAG_TOP) ? MAG_TOP : mag_w;
    wire [9:0] win_w = THR_BASE_MV + 10'(THR_STEP_MV * {6'h00, thresh_reg});
    wire [1:0] res_w = bias_reg[BIAS_RES_LSB +: 2];
    // Reserved code keeps both bias switches open rather than guess
    wire res_ok_w = (res_w != BIAS_RES_RSVD);
    wire pol_w = dc_cfg_reg[DC_POL_BIT];
    wire src_on_w = (mag_w != MAG_OFF);

    // One short flop per register so each reset value sits beside its output
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dc_cfg_reg <= REG_RESET;
        end else if (clk_en) begin
            dc_cfg_reg <= dc_cfg_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            thresh_reg <= 4'h0;
        end else if (clk_en) begin
            thresh_reg <= thresh_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan_reg <= 3'h0;
        end else if (clk_en) begin
            chan_reg <= chan_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bias_reg <= 4'h0;
        end else if (clk_en) begin
            bias_reg <= bias_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            int_en_reg <= REG_RESET;
        end else if (clk_en) begin
            int_en_reg <= int_en_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= REG_RESET;
        end else if (clk_en) begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            prdata <= prdata_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else if (clk_en) begin
            pready <= pready_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pslverr <= pslverr_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= irq_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lead_on_active <= 1'b0;
        end else if (clk_en) begin
            lead_on_active <= lon_run_w;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lead_off_active <= 1'b0;
        end else if (clk_en) begin
            lead_off_active <= loff_run_w;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            external_leadoff_select <= 1'b0;
        end else if (clk_en) begin
            external_leadoff_select <= dc_cfg_reg[DC_EXT_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            drive_monitor_active <= 1'b0;
        end else if (clk_en) begin
            drive_monitor_active <= drv_run_w;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pos_source_current <= 1'b0;
        end else if (clk_en) begin
            pos_source_current <= src_on_w && !pol_w;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            neg_source_current <= 1'b0;
        end else if (clk_en) begin
            neg_source_current <= src_on_w && pol_w;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            leadoff_current_magnitude <= 3'h0;
        end else if (clk_en) begin
            leadoff_current_magnitude <= mag_eff_w;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            leadoff_window_mv <= THR_BASE_MV;
        end else if (clk_en) begin
            leadoff_window_mv <= win_w;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bias_resistance_select <= 2'h0;
        end else if (clk_en) begin
            bias_resistance_select <= res_w;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pos_input_bias_enable <= 1'b0;
        end else if (clk_en) begin
            pos_input_bias_enable <= bias_reg[BIAS_POS_BIT] && res_ok_w;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            neg_input_bias_enable <= 1'b0;
        end else if (clk_en) begin
            neg_input_bias_enable <= bias_reg[BIAS_NEG_BIT] && res_ok_w;
        end
    end

endmodule

/* File: logic/ldb_pkg.sv */
/*
 * Constants for the lead detect and input bias register bank: register
 * indices, field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit APB with word-aligned byte addressing.
 */
package ldb_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_SELFTEST = 8'h44;
    localparam logic [7:0] IDX_DC_CFG = 8'h50;
    localparam logic [7:0] IDX_THRESH = 8'h51;
    localparam logic [7:0] IDX_CHAN_CTRL = 8'h52;
    localparam logic [7:0] IDX_BIAS_CFG = 8'h58;
    localparam logic [7:0] IDX_INT_EN = 8'h81;
    localparam logic [7:0] IDX_INT_CLR = 8'h82;
    localparam int ADDR_W = 10;

    // DC lead detect configuration fields
    localparam int DC_LON_BIT = 7;
    localparam int DC_LOFF_BIT = 6;
    localparam int DC_EXT_BIT = 5;
    localparam int DC_DRV_BIT = 4;
    localparam int DC_POL_BIT = 3;
    localparam int DC_MAG_LSB = 0;
    localparam int MAG_W = 3;
    localparam logic [2:0] MAG_OFF = 3'h0;
    localparam logic [2:0] MAG_TOP = 3'h5;

    // Threshold field and window in millivolts
    localparam int THR_W = 4;
    localparam logic [9:0] THR_BASE_MV = 10'h0D7;
    localparam logic [9:0] THR_STEP_MV = 10'h01E;

    // Channel control fields
    localparam int CH_I_BIT = 0;
    localparam int CH_Q_BIT = 1;
    localparam int CH_FAST_BIT = 2;

    // Bias configuration fields
    localparam int BIAS_NEG_BIT = 0;
    localparam int BIAS_POS_BIT = 1;
    localparam int BIAS_RES_LSB = 2;
    localparam logic [1:0] BIAS_RES_RSVD = 2'h3;

    // Status and interrupt layout
    localparam int ST_NL_BIT = 0;
    localparam int ST_NH_BIT = 1;
    localparam int ST_PL_BIT = 2;
    localparam int ST_PH_BIT = 3;
    localparam int ST_DRV_BIT = 4;
    localparam int ST_LON_BIT = 7;
    localparam logic [7:0] ST_MASK = 8'h9F;

    localparam logic [7:0] REG_RESET = 8'h00;

    // Persistence filter delay
    localparam int PERSIST_MS = 128;
    localparam int CLK_KHZ = 100000;
    localparam int PERSIST_CYCLES = PERSIST_MS * CLK_KHZ;
endpackage

/* File: bench/ldb_checker.sv */
/* Port checks for the lead detect bank.
   Bound to ldb_bank from the bench; sees its ports only. */
`timescale 1ns/1ps
module ldb_checker import ldb_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset, low active
    input wire logic clk_en, // Clock enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic lead_on_active, // Lead-on running
    input wire logic lead_off_active, // Lead-off running
    input wire logic pos_source_current, // Positive sources
    input wire logic neg_source_current, // Negative sources
    input wire logic [2:0] leadoff_current_magnitude, // Magnitude
    input wire logic [9:0] leadoff_window_mv, // Half window
    input wire logic [1:0] bias_resistance_select, // Bias code
    input wire logic pos_input_bias_enable, // Positive bias
    input wire logic neg_input_bias_enable // Negative bias
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire access = psel && penable && !pready && clk_en;
    wire st_wr = pwrite && paddr == {IDX_SELFTEST, 2'h0};
    wire [9:0] win_ofs = leadoff_window_mv - THR_BASE_MV;
    wait_state_a: assert property (access |=> pready ##1 !pready)
        else $error("answer not a single pulse after one wait");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data leaks");
    ro_selftest_a: assert property (pready && st_wr |-> pslverr)
        else $error("trim write accepted");
    det_excl_a: assert property (!(lead_on_active && lead_off_active))
        else $error("both detectors running");
    mag_clamp_a: assert property (leadoff_current_magnitude <= MAG_TOP)
        else $error("magnitude beyond top code");
    src_off_a: assert property (leadoff_current_magnitude == MAG_OFF |->
        !pos_source_current && !neg_source_current) else $error("source on at zero");
    src_dir_a: assert property (!(pos_source_current && neg_source_current))
        else $error("both inputs sourcing");
    win_step_a: assert property (win_ofs % THR_STEP_MV == 10'h0 && win_ofs <= 10'h1C2)
        else $error("window off the step grid");
    bias_rsvd_a: assert property (bias_resistance_select == BIAS_RES_RSVD |->
        !pos_input_bias_enable && !neg_input_bias_enable) else $error("bias on reserved");
endmodule

/* File: bench/ldb_electrodes.sv */
/* Electrode side model: turns a lead condition word into comparator
   and monitor levels. Assumes the bench changes the word at clock edges. */
`timescale 1ns/1ps
module ldb_electrodes (
    input wire logic ref_clk, // Clock
    input wire logic [5:0] lead_state, // {on, drive, ph, pl, nh, nl}
    output logic [3:0] window_cmp, // Window comparators
    output logic drive_excess, // Drive swing too large
    output logic lead_on_sense // Lead-on comparator
);
    // Comparators settle a clock after the electrode moves
    always_ff @(posedge ref_clk) begin
        {lead_on_sense, drive_excess, window_cmp} <= lead_state;
    end
endmodule

/* File: bench/ldb_bank_tb.sv */
/* Self-checking bench for ldb_bank with the electrode model.
   Assumes a short persistence length so the filter runs in a few clocks. */
`timescale 1ns/1ps
module ldb_bank_tb import ldb_pkg::*; ;
    localparam int PLEN = 8;
    typedef struct {logic [7:0] cfg, thr, chan, bias; logic [22:0] exp;} ldb_row_t;
    logic ref_clk = 1'h0;
    logic nrst = 1'h0;
    logic clk_en = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [7:0] selftest_resistor_error = 8'hC0;
    logic [5:0] lead_state = 6'h0;
    logic [31:0] prdata, rd;
    logic [3:0] window_cmp;
    logic [2:0] leadoff_current_magnitude;
    logic [9:0] leadoff_window_mv;
    logic [1:0] bias_resistance_select;
    logic pready, pslverr, irq, err, drive_excess, lead_on_sense, lead_on_active;
    logic lead_off_active, external_leadoff_select, drive_monitor_active;
    logic pos_source_current, neg_source_current, pos_input_bias_enable, neg_input_bias_enable;
    int n_fail = 0;
    int samples_checked = 0;
    wire [22:0] outs = {lead_on_active, lead_off_active, external_leadoff_select,
        drive_monitor_active, pos_source_current, neg_source_current, leadoff_current_magnitude,
        leadoff_window_mv, bias_resistance_select, pos_input_bias_enable, neg_input_bias_enable};
    // Flags, magnitude, window, bias code and switches per row
    ldb_row_t rows [5] = '{'{8'h80, 8'h0, 8'h0, 8'h00, {6'h20, 3'h0, 10'h0D7, 4'h0}},
        '{8'hC1, 8'hF, 8'h1, 8'h02, {6'h12, 3'h1, 10'h299, 4'h2}},
        '{8'h4E, 8'h5, 8'h2, 8'h05, {6'h11, 3'h5, 10'h16D, 4'h5}},
        '{8'h37, 8'hA, 8'h0, 8'h0B, {6'h0E, 3'h5, 10'h203, 4'hB}},
        '{8'h88, 8'h1, 8'h3, 8'h0F, {6'h00, 3'h0, 10'h0F5, 4'hC}}};
    logic [7:0] regs [7] = '{IDX_STATUS, IDX_DC_CFG, IDX_THRESH, IDX_CHAN_CTRL,
        IDX_BIAS_CFG, IDX_INT_EN, IDX_INT_CLR};
    ldb_bank #(.PERSIST_LEN(PLEN)) u_ldb_bank (.ref_clk, .nrst, .clk_en, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .window_cmp, .drive_excess,
        .lead_on_sense, .selftest_resistor_error, .lead_on_active, .lead_off_active,
        .external_leadoff_select, .drive_monitor_active, .pos_source_current,
        .neg_source_current, .leadoff_current_magnitude, .leadoff_window_mv,
        .bias_resistance_select, .pos_input_bias_enable, .neg_input_bias_enable, .irq);
    ldb_electrodes u_ldb_electrodes (.ref_clk, .lead_state, .window_cmp, .drive_excess,
        .lead_on_sense);
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wrap_up();
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100us;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'h1;
        chk("reset outputs", {6'h0, 3'h0, 10'h0D7, 4'h0}, outs);
        foreach (regs[i]) begin
            apb(1'h0, regs[i], 32'h0);
            chk("reset register", REG_RESET, rd);
        end
        foreach (rows[i]) begin
            apb(1'h1, IDX_DC_CFG, rows[i].cfg);
            apb(1'h1, IDX_THRESH, rows[i].thr);
            apb(1'h1, IDX_CHAN_CTRL, rows[i].chan);
            apb(1'h1, IDX_BIAS_CFG, rows[i].bias);
            repeat (2) @(posedge ref_clk);
            chk("outputs", rows[i].exp, outs);
            apb(1'h0, IDX_DC_CFG, 32'h0);
            chk("config readback", rows[i].cfg, rd);
        end
        for (int t = 0; t < 16; t++) begin
            apb(1'h1, IDX_DC_CFG, t % 8);
            apb(1'h1, IDX_THRESH, t);
            repeat (2) @(posedge ref_clk);
            chk("magnitude", (t % 8) > 5 ? 5 : t % 8, leadoff_current_magnitude);
            chk("window", 215 + 30 * t, leadoff_window_mv);
        end
        apb(1'h0, IDX_SELFTEST, 32'h0);
        chk("trim read", 32'hFFFFFFC0, rd);
        apb(1'h1, IDX_SELFTEST, 32'h0);
        chk("trim write refused", 1'h1, err);
        apb(1'h1, IDX_STATUS, 32'hFF);
        chk("status write refused", 1'h1, err);
        apb(1'h0, 8'h7F, 32'h0);
        chk("unmapped error", 1'h1, err);
        chk("unmapped read", 32'h0, rd);
        apb(1'h1, IDX_INT_EN, 32'h9F);
        apb(1'h1, IDX_CHAN_CTRL, 32'h1);
        apb(1'h1, IDX_DC_CFG, 32'h40);
        // Short excursion, brief return, then a second one that is held: no report yet
        lead_state <= 6'h08;
        repeat (PLEN - 2) @(posedge ref_clk);
        lead_state <= 6'h00;
        repeat (2) @(posedge ref_clk);
        lead_state <= 6'h08;
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("status after bounce", 32'h0, rd);
        repeat (PLEN + 2) @(posedge ref_clk);
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("status persisted", 32'h08, rd);
        chk("irq enabled", 1'h1, irq);
        lead_state <= 6'h00;
        apb(1'h1, IDX_INT_CLR, 32'h08);
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("status cleared", 32'h0, rd);
        chk("irq cleared", 1'h0, irq);
        apb(1'h1, IDX_INT_EN, 32'h0);
        apb(1'h1, IDX_CHAN_CTRL, 32'h5);
        apb(1'h1, IDX_DC_CFG, 32'hC0);
        lead_state <= 6'h21;
        @(posedge ref_clk);
        lead_state <= 6'h20;
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("fast report", 32'h01, rd);
        chk("irq masked", 1'h0, irq);
        // Enable low: an excursion while frozen must leave no trace
        clk_en <= 1'h0;
        lead_state <= 6'h22;
        repeat (4) @(posedge ref_clk);
        lead_state <= 6'h20;
        repeat (2) @(posedge ref_clk);
        clk_en <= 1'h1;
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("frozen by enable", 32'h01, rd);
        apb(1'h1, IDX_INT_EN, 32'h01);
        repeat (2) @(posedge ref_clk);
        chk("irq unmasked", 1'h1, irq);
        apb(1'h1, IDX_INT_CLR, 32'h01);
        apb(1'h1, IDX_CHAN_CTRL, 32'h0);
        apb(1'h1, IDX_DC_CFG, 32'h90);
        lead_state <= 6'h30;
        repeat (3) @(posedge ref_clk);
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("lead on and drive", 32'h90, rd);
        nrst <= 1'h0;
        repeat (2) @(posedge ref_clk);
        chk("mid-run reset outputs", {6'h0, 3'h0, 10'h0D7, 4'h0}, outs);
        nrst <= 1'h1;
        apb(1'h0, IDX_DC_CFG, 32'h0);
        chk("config after reset", REG_RESET, rd);
        apb(1'h0, IDX_STATUS, 32'h0);
        chk("status after reset", REG_RESET, rd);
        wrap_up();
    end
endmodule
bind ldb_bank ldb_checker u_ldb_checker (.ref_clk, .nrst, .clk_en, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .lead_on_active, .lead_off_active, .pos_source_current,
    .neg_source_current, .leadoff_current_magnitude, .leadoff_window_mv,
    .bias_resistance_select, .pos_input_bias_enable, .neg_input_bias_enable);
